// ### core/spcd_decoder.sv
// sector protection command decoder top
// Contract
// - three-write entry selects one protection set
// - 90 then 00 leaves set
// - A0 then data at 77/00 programs lock
// - lock bits: hidden, persistent, key, once
// - both mode locks set aborts, stays persistent
// - key read at 000..003 full decode
// - key is four 16-bit words
// - seven-write key unlock sequence
// - program one or erase all persistent bits
// - erase pre-programs all persistent bits
// - status on data bit 0, 0 protected
// - freeze set and freeze status read
// - bank field from top address bits
// - unspecified address and data bits ignored
// - F0 write resets to array read, except when written as program data or as a key word
`timescale 1ns/1ns
module spcd_decoder #(
    parameter int AW    = 24,
    parameter bit BIG   = 1'b1,
    parameter int NSECT = 1024
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [15:0]   wdata,
    output logic      [15:0]   rdata,
    output logic               rdata_valid,
    output logic               array_mode,
    output logic               busy,
    output logic [NSECT-1:0]   persistent_sector_guard_bit,
    output logic [NSECT-1:0]   dynamic_sector_guard_bit,
    output logic               global_guard_freeze_bit,
    output logic               key_unlocked
);
    localparam int SW = AW - spcd_pkg::SECTOR_LSB;
    typedef enum logic [3:0] {
        SPCD_ARRAY, SPCD_U1, SPCD_U2, SPCD_SET, SPCD_CMD,
        SPCD_EXIT, SPCD_ERASE2, SPCD_K1, SPCD_KW, SPCD_KGO
    } spcd_state_e;
    typedef enum logic [2:0] {
        SPCD_M_LOCK, SPCD_M_KEY, SPCD_M_PERSIST, SPCD_M_FREEZE,
        SPCD_M_DYNAMIC
    } spcd_mode_e;
    initial assert (AW == 23 || AW == 24) else $error("AW must be 23 or 24");
    initial assert (NSECT >= (1 << SW)) else $error("NSECT too small");
    spcd_state_e state_r;
    spcd_mode_e  mode_r;
    logic [15:0] lock_r;
    logic [15:0] key_r [4];
    logic [15:0] try_r [4];
    logic        key_unlocked_r;
    logic        frz_r;
    logic [NSECT-1:0] pbit_r;
    logic [NSECT-1:0] dbit_r;
    logic [15:0] rdata_r;
    logic        rvalid_r;
    logic        erase_start;
    logic        seq_busy;
    logic        prog_all;
    logic        erase_all;
    // address and data fields; other bits ignored
    wire logic [11:0] a12  = addr[11:0];
    wire logic [7:0]  a8   = addr[7:0];
    wire logic [7:0]  d8   = wdata[7:0];
    wire logic [SW-1:0] sect = addr[AW-1:spcd_pkg::SECTOR_LSB];
    wire logic [7:0]  lock_addr = BIG ? spcd_pkg::LOCK_ADDR_BIG
                                      : spcd_pkg::LOCK_ADDR_SML;
    wire logic        is_reset = wr_en && d8 == spcd_pkg::CMD_RESET &&
                                 state_r != SPCD_KW && state_r != SPCD_SET;
    wire logic        in_set = state_r == spcd_state_e'(SPCD_CMD);
    wire logic        mode_bad = wdata[spcd_pkg::PERSIST_LOCK_POS] == 1'b0 &&
                                 wdata[spcd_pkg::KEY_LOCK_POS] == 1'b0;
    // command sequence state machine
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= SPCD_ARRAY;
            mode_r  <= SPCD_M_LOCK;
        end
        else if (is_reset)
            state_r <= SPCD_ARRAY;
        else if (wr_en)
        begin
            unique case (state_r)
                SPCD_ARRAY:
                    if (a12 == spcd_pkg::UNLOCK1_ADDR &&
                        d8 == spcd_pkg::UNLOCK1_DATA)
                        state_r <= SPCD_U1;
                SPCD_U1:
                    state_r <= (a12 == spcd_pkg::UNLOCK2_ADDR &&
                                d8 == spcd_pkg::UNLOCK2_DATA)
                               ? SPCD_U2 : SPCD_ARRAY;
                SPCD_U2:
                begin
                    // bank field of entry write is don't care here
                    state_r <= SPCD_ARRAY;
                    if (a12 == spcd_pkg::UNLOCK1_ADDR)
                    begin
                        state_r <= SPCD_CMD;
                        unique case (d8)
                            spcd_pkg::MODE_LOCK:    mode_r <= SPCD_M_LOCK;
                            spcd_pkg::MODE_KEY:     mode_r <= SPCD_M_KEY;
                            spcd_pkg::MODE_PERSIST: mode_r <= SPCD_M_PERSIST;
                            spcd_pkg::MODE_FREEZE:  mode_r <= SPCD_M_FREEZE;
                            spcd_pkg::MODE_DYNAMIC: mode_r <= SPCD_M_DYNAMIC;
                            default:                state_r <= SPCD_ARRAY;
                        endcase
                    end
                end
                SPCD_CMD:
                    if (d8 == spcd_pkg::CMD_EXIT1)
                        state_r <= SPCD_EXIT;
                    else if (d8 == spcd_pkg::CMD_PROGRAM)
                        state_r <= SPCD_SET;
                    else if (d8 == spcd_pkg::CMD_ERASE1 &&
                             mode_r == SPCD_M_PERSIST)
                        state_r <= SPCD_ERASE2;
                    else if (d8 == spcd_pkg::CMD_UNLOCK1 &&
                             mode_r == SPCD_M_KEY && a8 == 8'h00)
                        state_r <= SPCD_K1;
                SPCD_EXIT:
                    state_r <= (d8 == spcd_pkg::CMD_EXIT2)
                               ? SPCD_ARRAY : SPCD_CMD;
                SPCD_SET, SPCD_ERASE2, SPCD_KGO: state_r <= SPCD_CMD;
                SPCD_K1:
                    state_r <= (d8 == spcd_pkg::CMD_UNLOCK2 && a8 == 8'h00)
                               ? SPCD_KW : SPCD_CMD;
                SPCD_KW:
                    if (a8[1:0] == 2'b11)
                        state_r <= SPCD_KGO;
                default:     state_r <= SPCD_ARRAY;
            endcase
        end
    end

    // lock program with dual mode abort; bits only go from 1 to 0
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            lock_r <= spcd_pkg::LOCK_RESET;
        else if (wr_en && state_r == SPCD_SET && mode_r == SPCD_M_LOCK &&
                 a8 == lock_addr && !mode_bad)
            lock_r[spcd_pkg::ONCE_POS:0] <=
                lock_r[spcd_pkg::ONCE_POS:0] & wdata[3:0];
    end

    // key words and unlock compare
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            key_r <= '{default: spcd_pkg::KEY_RESET};
            try_r <= '{default: 16'h0000};
            key_unlocked_r <= 1'b0;
        end
        else
        begin
            if (wr_en && state_r == SPCD_SET && mode_r == SPCD_M_KEY &&
                lock_r[spcd_pkg::KEY_LOCK_POS])
                key_r[a8[1:0]] <= wdata;
            if (wr_en && state_r == SPCD_KW)
                try_r[a8[1:0]] <= wdata;
            if (wr_en && state_r == SPCD_KGO &&
                d8 == spcd_pkg::CMD_UNLOCK_GO && a8 == 8'h00)
                key_unlocked_r <= {try_r[0], try_r[1], try_r[2], try_r[3]} ==
                                  {key_r[0], key_r[1], key_r[2], key_r[3]};
        end
    end
    assign erase_start = wr_en && state_r == SPCD_ERASE2 &&
                         a8 == 8'h00 && d8 == spcd_pkg::CMD_ERASE2 &&
                         !frz_r && !seq_busy;
    spcd_erase_seq #(
        .NSECT     (NSECT)
    ) u_erase (
        .clk       (clk),
        .rst_n     (rst_n),
        .start     (erase_start),
        .busy      (seq_busy),
        .prog_all  (prog_all),
        .erase_all (erase_all)
    );

    // persistent guard bits: 0 means protected
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pbit_r <= '1;
        else if (prog_all)
            pbit_r <= '0;
        else if (erase_all)
            pbit_r <= '1;
        else if (wr_en && state_r == SPCD_SET &&
                 mode_r == SPCD_M_PERSIST &&
                 d8 == spcd_pkg::DATA_SET && !frz_r)
            pbit_r[sect] <= 1'b0;
    end

    // freeze bit, set once until reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            frz_r <= 1'b0;
        else if (wr_en && state_r == SPCD_SET &&
                 mode_r == SPCD_M_FREEZE && d8 == spcd_pkg::DATA_SET)
            frz_r <= 1'b1;
    end

    // volatile guard bits: 0 protected, 1 unprotected
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            dbit_r <= '1;
        else if (wr_en && state_r == SPCD_SET &&
                 mode_r == SPCD_M_DYNAMIC)
        begin
            if (d8 == spcd_pkg::DATA_SET)
                dbit_r[sect] <= 1'b0;
            else if (d8 == spcd_pkg::DATA_CLEAR)
                dbit_r[sect] <= 1'b1;
        end
    end

    // register read path
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= rd_en && in_set;
            rdata_r  <= 16'h0000;
            if (rd_en && in_set)
            begin
                unique case (mode_r)
                    SPCD_M_LOCK:
                        if (a8 == lock_addr)
                            rdata_r <= lock_r;
                    SPCD_M_KEY:
                        if (addr[AW-1:2] == '0 &&
                            lock_r[spcd_pkg::KEY_LOCK_POS])
                            rdata_r <= key_r[addr[1:0]];
                    SPCD_M_PERSIST:
                        rdata_r <= {15'h0000, pbit_r[sect]};
                    SPCD_M_FREEZE:
                        rdata_r <= {15'h0000, !frz_r};
                    SPCD_M_DYNAMIC:
                        rdata_r <= {15'h0000, dbit_r[sect]};
                    default: rdata_r <= 16'h0000;
                endcase
            end
        end
    end

    assign rdata       = rdata_r;
    assign rdata_valid = rvalid_r;
    assign array_mode  = (state_r == SPCD_ARRAY);
    assign busy        = seq_busy;
    assign persistent_sector_guard_bit = pbit_r;
    assign dynamic_sector_guard_bit    = dbit_r;
    assign global_guard_freeze_bit     = frz_r;
    assign key_unlocked                = key_unlocked_r;

    property p_entry;
        @(posedge clk) disable iff (!rst_n)
        wr_en && state_r == SPCD_U2 && a12 == spcd_pkg::UNLOCK1_ADDR &&
        d8 == spcd_pkg::MODE_DYNAMIC |=> in_set && mode_r == SPCD_M_DYNAMIC;
    endproperty
    a_entry: assert property (p_entry)
        else $error("entry did not open volatile set");
    property p_exit;
        @(posedge clk) disable iff (!rst_n)
        wr_en && state_r == SPCD_EXIT && d8 == spcd_pkg::CMD_EXIT2
        |=> array_mode;
    endproperty
    a_exit: assert property (p_exit)
        else $error("exit did not return to array mode");
    property p_abort;
        @(posedge clk) disable iff (!rst_n)
        wr_en && state_r == SPCD_SET && mode_r == SPCD_M_LOCK && mode_bad
        |=> lock_r == $past(lock_r);
    endproperty
    a_abort: assert property (p_abort)
        else $error("dual mode lock was not aborted");
    property p_status_bit;
        @(posedge clk) disable iff (!rst_n)
        rd_en && in_set && mode_r == SPCD_M_FREEZE
        |=> rdata_valid && rdata == {15'h0000, !frz_r};
    endproperty
    a_status_bit: assert property (p_status_bit)
        else $error("freeze status wrong");
    property p_freeze_stays;
        @(posedge clk) disable iff (!rst_n)
        frz_r |=> frz_r && !erase_start;
    endproperty
    a_freeze_stays: assert property (p_freeze_stays)
        else $error("freeze bit lost or erase allowed");
    property p_reset_cmd;
        @(posedge clk) disable iff (!rst_n)
        is_reset |=> array_mode;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd)
        else $error("reset command ignored");
    property p_dyn_clear;
        @(posedge clk) disable iff (!rst_n)
        wr_en && state_r == SPCD_SET && mode_r == SPCD_M_DYNAMIC &&
        d8 == spcd_pkg::DATA_CLEAR |=> dbit_r[$past(sect)];
    endproperty
    a_dyn_clear: assert property (p_dyn_clear)
        else $error("volatile unprotect failed");
    property p_key_read;
        @(posedge clk) disable iff (!rst_n)
        rd_en && in_set && mode_r == SPCD_M_KEY && addr[AW-1:2] != '0
        |=> rdata == 16'h0000;
    endproperty
    a_key_read: assert property (p_key_read)
        else $error("key read not fully decoded");
    c_entry_lock: cover property (@(posedge clk) disable iff (!rst_n)
        in_set && mode_r == SPCD_M_LOCK);
    c_unlock: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(key_unlocked_r));
    c_erase: cover property (@(posedge clk) disable iff (!rst_n)
        erase_all);
    c_exit: cover property (@(posedge clk) disable iff (!rst_n)
        state_r == SPCD_EXIT ##1 array_mode);
endmodule : spcd_decoder

// ### core/spcd_erase_seq.sv
// pre-program then erase sequencer for persistent guard bits
`timescale 1ns/1ns
module spcd_erase_seq #(
    parameter int NSECT = 1024
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    output logic                  busy,
    output logic                  prog_all,
    output logic                  erase_all
);
    typedef enum logic [1:0] {SPCD_IDLE, SPCD_PROG, SPCD_ERASE} spcd_seq_e;
    spcd_seq_e  state_r;
    logic [3:0] cnt_r;

    initial assert (NSECT > 0) else $error("NSECT must be positive");

    // program all bits first, then erase all
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= SPCD_IDLE;
            cnt_r   <= 4'h0;
        end
        else
        begin
            unique case (state_r)
                SPCD_IDLE:
                begin
                    if (start)
                    begin
                        state_r <= SPCD_PROG;
                        cnt_r   <= 4'(spcd_pkg::PERSIST_BUSY_CYC - 1);
                    end
                end
                SPCD_PROG:
                begin
                    if (cnt_r == 4'h0)
                    begin
                        state_r <= SPCD_ERASE;
                        cnt_r   <= 4'(spcd_pkg::PERSIST_BUSY_CYC - 1);
                    end
                    else
                        cnt_r <= cnt_r - 4'h1;
                end
                SPCD_ERASE:
                begin
                    if (cnt_r == 4'h0)
                        state_r <= SPCD_IDLE;
                    else
                        cnt_r <= cnt_r - 4'h1;
                end
                default: state_r <= SPCD_IDLE;
            endcase
        end
    end

    assign busy      = (state_r != SPCD_IDLE);
    assign prog_all  = (state_r == SPCD_PROG) && (cnt_r == 4'h0);
    assign erase_all = (state_r == SPCD_ERASE) && (cnt_r == 4'h0);

    property p_prog_before_erase;
        @(posedge clk) disable iff (!rst_n)
        start && !busy |-> ##4 prog_all ##4 erase_all;
    endproperty
    a_prog_before_erase: assert property (p_prog_before_erase)
        else $error("erase did not follow pre-program");
endmodule : spcd_erase_seq

// ### inc/spcd_pkg.sv
// constants for the sector protection command decoder
package spcd_pkg;
    localparam logic [11:0] UNLOCK1_ADDR   = 12'h555;
    localparam logic [11:0] UNLOCK2_ADDR   = 12'h2aa;
    localparam logic [7:0]  UNLOCK1_DATA   = 8'haa;
    localparam logic [7:0]  UNLOCK2_DATA   = 8'h55;
    localparam logic [7:0]  MODE_LOCK      = 8'h40;
    localparam logic [7:0]  MODE_KEY       = 8'h60;
    localparam logic [7:0]  MODE_PERSIST   = 8'hc0;
    localparam logic [7:0]  MODE_FREEZE    = 8'h50;
    localparam logic [7:0]  MODE_DYNAMIC   = 8'he0;
    localparam logic [7:0]  CMD_EXIT1      = 8'h90;
    localparam logic [7:0]  CMD_EXIT2      = 8'h00;
    localparam logic [7:0]  CMD_PROGRAM    = 8'ha0;
    localparam logic [7:0]  CMD_ERASE1     = 8'h80;
    localparam logic [7:0]  CMD_ERASE2     = 8'h30;
    localparam logic [7:0]  CMD_RESET      = 8'hf0;
    localparam logic [7:0]  CMD_UNLOCK1    = 8'h25;
    localparam logic [7:0]  CMD_UNLOCK2    = 8'h03;
    localparam logic [7:0]  CMD_UNLOCK_GO  = 8'h29;
    localparam logic [7:0]  DATA_SET       = 8'h00;
    localparam logic [7:0]  DATA_CLEAR     = 8'h01;
    localparam logic [7:0]  LOCK_ADDR_BIG  = 8'h77;
    localparam logic [7:0]  LOCK_ADDR_SML  = 8'h00;
    // lock register fields
    localparam int          HIDDEN_LOCK_POS  = 0;
    localparam int          PERSIST_LOCK_POS = 1;
    localparam int          KEY_LOCK_POS     = 2;
    localparam int          ONCE_POS         = 3;
    localparam logic [15:0] LOCK_RESET       = 16'hffff;
    localparam logic [15:0] KEY_RESET        = 16'hffff;
    // sector address starts at this address bit
    localparam int          SECTOR_LSB       = 14;
    localparam int          BANK_LSB         = 20;
    // cycles each phase of a persistent erase (pre-program, erase) stays busy
    localparam int          PERSIST_BUSY_CYC = 4;
endpackage : spcd_pkg

// ### test/spcd_host.sv
// host controller model issuing flash write and read bus cycles
`timescale 1ns/1ns
module spcd_host #(
    parameter int AW = 24
) (
    input  wire logic          clk,
    output logic               wr_en,
    output logic               rd_en,
    output logic [AW-1:0]      addr,
    output logic [15:0]        wdata,
    input  wire logic [15:0]   rdata,
    input  wire logic          rdata_valid
);
    // idle bus at time zero
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr  = '0;
        wdata = 16'h0000;
    end

    // one write cycle; a released bus shows the inverse of its last value
    task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        wr_en = 1'b1;
        addr  = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        addr  = ~a;
        wdata = ~d;
    endtask : wr

    // one read cycle; the answer is taken one cycle after the request
    task automatic rd(input logic [AW-1:0] a, output logic [15:0] d,
                      output logic v);
        @(posedge clk);
        #1;
        rd_en = 1'b1;
        addr  = a;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        addr  = ~a;
        d     = rdata;
        v     = rdata_valid;
    endtask : rd
endmodule : spcd_host

// ### test/tb_spcd_decoder.sv
// self-checking testbench for the sector protection command decoder
`timescale 1ns/1ns
module tb_spcd_decoder;
    localparam int AW    = 24;
    localparam int NSECT = 1024;
    logic             clk;
    logic             rst_n;
    logic             wr_en;
    logic             rd_en;
    logic [AW-1:0]    addr;
    logic [15:0]      wdata;
    logic [15:0]      rdata;
    logic             rdata_valid;
    logic             array_mode;
    logic             busy;
    logic [NSECT-1:0] pbits;
    logic [NSECT-1:0] dbits;
    logic             freeze;
    logic             key_unlocked;
    int               fails;
    int               total_checks;
    logic [31:0]      seed_r;
    logic [15:0]      key_w [4];
    logic [15:0]      rd_d;
    logic             rd_v;
    logic [15:0]      lk;
    logic [15:0]      r;
    logic             saw0;

    spcd_decoder #(.AW(AW), .BIG(1'b1), .NSECT(NSECT)) dut (
        .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .rdata(rdata),
        .rdata_valid(rdata_valid), .array_mode(array_mode), .busy(busy),
        .persistent_sector_guard_bit(pbits),
        .dynamic_sector_guard_bit(dbits),
        .global_guard_freeze_bit(freeze), .key_unlocked(key_unlocked));

    spcd_host #(.AW(AW)) host (
        .clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .rdata_valid(rdata_valid));

    // next random word from the bench shift register
    function automatic logic [15:0] rnd();
        seed_r = {seed_r[30:0],
                  seed_r[31] ^ seed_r[21] ^ seed_r[1] ^ seed_r[0]};
        return seed_r[15:0];
    endfunction : rnd

    // expected lock value: a program with both mode locks low is dropped
    function automatic logic [15:0] lock_exp(input logic [15:0] o,
                                             input logic [15:0] d);
        return (!d[1] && !d[2]) ? o : (o & d);
    endfunction : lock_exp

    // sector address with don't-care low bits
    function automatic logic [23:0] sec_addr(input logic [15:0] s,
                                             input logic [15:0] lo);
        return {s[9:0], lo[13:0]};
    endfunction : sec_addr

    // compare a data word
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_word

    // compare a single flag
    task automatic chk_bit(input logic g, input logic e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_bit

    // prints the counts and the verdict, then ends the run
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // three-write entry with random bank bits on the last write
    task automatic enter(input logic [7:0] m);
        logic [15:0] q;
        q = rnd();
        host.wr(24'h000555, 16'h00aa);
        host.wr(24'h0002aa, 16'h0055);
        host.wr({q[3:0], 8'h00, 12'h555}, {q[15:8], m});
        chk_bit(array_mode, 1'b0);
    endtask : enter

    // two-write exit at random addresses
    task automatic leave;
        logic [15:0] q;
        q = rnd();
        host.wr({q[7:0], q}, 16'h0090);
        host.wr({q, q[7:0]}, 16'h0000);
        chk_bit(array_mode, 1'b1);
    endtask : leave

    // seven-write unlock, word 2 optionally corrupted
    task automatic unlock(input logic [15:0] flip);
        host.wr(24'h000000, 16'h0025);
        host.wr(24'h000000, 16'h0003);
        for (int i = 0; i < 4; i++)
            host.wr(24'(i), key_w[i] ^ ((i == 2) ? flip : 16'h0000));
        host.wr(24'h000000, 16'h0029);
    endtask : unlock

    // clock source
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // watchdog
    initial
    begin
        #100000;
        fails++;
        summarize();
    end

    // main test sequence
    initial
    begin
        rst_n = 1'b0;
        fails = 0;
        total_checks = 0;
        seed_r = 32'h999d;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk_bit(array_mode, 1'b1);
        chk_bit(&pbits, 1'b1);
        chk_bit(&dbits, 1'b1);
        chk_bit(freeze, 1'b0);
        host.rd(24'h000077, rd_d, rd_v);
        chk_bit(rd_v, 1'b0);
        $display("test reset done");
        // lock register program, both-locks abort, read back
        enter(spcd_pkg::MODE_LOCK);
        host.rd(24'h000077, rd_d, rd_v);
        chk_bit(rd_v, 1'b1);
        chk_word(rd_d, spcd_pkg::LOCK_RESET);
        lk = lock_exp(spcd_pkg::LOCK_RESET, 16'hfffd);
        host.wr(24'h123456, 16'h00a0);
        host.wr(24'h000077, 16'hfffd);
        host.rd(24'h000077, rd_d, rd_v);
        chk_word(rd_d, lk);
        chk_bit(rd_d[spcd_pkg::PERSIST_LOCK_POS], 1'b0);
        lk = lock_exp(lk, 16'hfff9);
        host.wr(24'h000000, 16'h00a0);
        host.wr(24'h000077, 16'hfff9);
        host.rd(24'h000077, rd_d, rd_v);
        chk_word(rd_d, lk);
        leave();
        $display("test lock done");
        // key program, read back, unlock right and wrong
        enter(spcd_pkg::MODE_KEY);
        for (int i = 0; i < 4; i++)
        begin
            key_w[i] = rnd();
            host.wr(24'hfff000, 16'h00a0);
            host.wr(24'(i), key_w[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            host.rd(24'(i), rd_d, rd_v);
            chk_word(rd_d, key_w[i]);
        end
        host.rd(24'h100001, rd_d, rd_v);
        chk_word(rd_d, 16'h0000);
        unlock(16'h0000);
        chk_bit(key_unlocked, 1'b1);
        unlock(16'h0001);
        chk_bit(key_unlocked, 1'b0);
        leave();
        $display("test key done");
        // persistent bit program, status read, erase
        enter(spcd_pkg::MODE_PERSIST);
        r = rnd();
        host.wr(24'h000aaa, 16'h00a0);
        host.wr(sec_addr(r, ~r), 16'h5a00);
        chk_bit(pbits[r[9:0]], 1'b0);
        host.rd(sec_addr(r, r), rd_d, rd_v);
        chk_bit(rd_d[0], 1'b0);
        host.rd(sec_addr(r ^ 16'h0001, r), rd_d, rd_v);
        chk_bit(rd_d[0], 1'b1);
        host.wr(24'h000aaa, 16'h0080);
        host.wr(24'h000000, 16'h0030);
        saw0 = 1'b0;
        for (int n = 0; n < 20; n++)
        begin
            @(posedge clk);
            #1;
            if (pbits === '0)
                saw0 = 1'b1;
        end
        chk_bit(saw0, 1'b1);
        chk_bit(&pbits, 1'b1);
        chk_bit(busy, 1'b0);
        leave();
        $display("test persistent done");
        // volatile bit set, read, clear on random sectors, then reset
        enter(spcd_pkg::MODE_DYNAMIC);
        for (int k = 0; k < 4; k++)
        begin
            r = rnd();
            host.wr(24'h000000, 16'h00a0);
            host.wr(sec_addr(r, r), 16'h0000);
            host.rd(sec_addr(r, ~r), rd_d, rd_v);
            chk_bit(rd_d[0], 1'b0);
            host.wr(24'h000000, 16'h00a0);
            host.wr(sec_addr(r, r), 16'h0001);
            chk_bit(dbits[r[9:0]], 1'b1);
        end
        host.wr(24'h0abcde, 16'h00f0);
        chk_bit(array_mode, 1'b1);
        $display("test volatile done");
        // freeze, bank status read, frozen program ignored
        enter(spcd_pkg::MODE_FREEZE);
        host.wr(24'h00ffff, 16'h00a0);
        host.wr(24'h3f0000, 16'h0000);
        chk_bit(freeze, 1'b1);
        host.rd(24'h300000, rd_d, rd_v);
        chk_bit(rd_d[0], 1'b0);
        leave();
        enter(spcd_pkg::MODE_PERSIST);
        host.wr(24'h000000, 16'h00a0);
        host.wr(sec_addr(16'h0155, 16'h0000), 16'h0000);
        chk_bit(&pbits, 1'b1);
        leave();
        $display("test freeze done");
        summarize();
    end
endmodule : tb_spcd_decoder
